// [design/asr_pkg.sv]
// Purpose: Constants shared by the asynchronous serial receiver.
// Assumes: 32-bit APB, word-aligned registers at four times their index.
// Notes: Register indices are kept as printed; byte address is index*4.
package asr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices (byte address = index * 4)
  localparam int unsigned ADDR_W = 12;
  localparam logic [9:0] IDX_FLAGS = 10'h00c;
  localparam logic [9:0] IDX_RSC = 10'h018;
  localparam logic [9:0] IDX_TXB = 10'h019;
  localparam logic [9:0] IDX_RXB = 10'h01a;
  localparam logic [9:0] IDX_IEN = 10'h08c;
  localparam logic [9:0] IDX_TSC = 10'h098;
  localparam logic [9:0] IDX_BRG = 10'h099;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int unsigned RSC_SERIAL_PORT_ENABLE = 7;
  localparam int unsigned RSC_RX9 = 6;
  localparam int unsigned RSC_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int unsigned RSC_ADDRESS_DETECT_ENABLE = 3;
  localparam int unsigned TSC_SYNC = 4;
  localparam int unsigned TSC_HIGH_BAUD_RATE_SELECT = 2;
  localparam int unsigned FLG_RCV = 5;
  localparam int unsigned IEN_RCV = 5;
  localparam int unsigned ENT_FRAMING_ERROR = 9;
  localparam int unsigned ENT_NINTH = 8;
  localparam int unsigned ENTRY_W = 10;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and write masks
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_RSC = 8'h00;
  localparam logic [7:0] RST_TXB = 8'h00;
  localparam logic [7:0] RST_IEN = 8'h00;
  localparam logic [7:0] RST_TSC = 8'h02;
  localparam logic [7:0] RST_BRG = 8'h00;
  localparam logic [7:0] RSC_WMASK = 8'hf8;
  localparam logic [7:0] TSC_WMASK = 8'hf5;
  localparam logic [7:0] TSC_RO_SET = 8'h02;
  localparam logic [7:0] FLG_WMASK = 8'hdf;

  ////////////////////////////////////////////////////////////////////////////
  // Oversampling timing, in sixteenths of a bit
  localparam logic [3:0] SMP_A = 4'h7;
  localparam logic [3:0] SMP_B = 4'h8;
  localparam logic [3:0] SMP_C = 4'h9;
  localparam logic [3:0] BIT_END = 4'hf;
  localparam logic [1:0] LOW_PRE_LAST = 2'h3;
  localparam logic [3:0] LAST_BIT8 = 4'h7;
  localparam logic [3:0] LAST_BIT9 = 4'h8;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_DATA = 2'b10,
    ST_STOP = 2'b11
  } asr_state_e;

endpackage : asr_pkg

// [design/asr_receiver.sv]
// Purpose: Asynchronous serial receiver with two-deep buffer, APB slave.
// Assumes: 50 MHz mclk_i, synchronous active-low reset, one wait state.
// Notes: Transmit buffer is storage only; transmit control's sync and high baud select bits steer the receiver; no transmitter lives here.
//
// Contract
// (RQ1) Recover bits at sixteen times bit rate
// (RQ2) Accept frames only while receive enable set
// (RQ3) After stop, load buffer, set flag
// (RQ4) Flag read-only, clears when buffer empty
// (RQ5) Interrupt request gated by enable bit
// (RQ6) Buffer holds two words
// (RQ7) Full buffer at stop sets overrun, drops
// (RQ8) Overrun cleared only by toggling receive enable
// (RQ9) Overrun blocks all buffer loads
// (RQ10) Zero stop bit sets framing error
// (RQ11) Framing and ninth bit stored per entry
// (RQ12) Software reads status before buffer
// (RQ13) Reads return bytes in arrival order
// (RQ14) Async needs sync clear, port enable set
// (RQ15) Nine-bit mode receives ninth data bit
// (RQ16) Address detect keeps data words out
// (RQ17) High baud select picks fast range
// (RQ18) Frame: start, eight/nine data, stop
// (RQ19) Data bits arrive least significant first
// (RQ20) Baud generator gives x16 or x64 tick
// (RQ21) Ninth bit one marks address word
// (RQ22) Start on falling edge, mid-bit sampling
`timescale 1ns/1ns
module asr_receiver
  import asr_pkg::*;
#(
  parameter int unsigned DEPTH = 2
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic receive_pin_i,
  output logic receive_irq_o
);

  localparam int unsigned PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0] CNT_FULL = (PTR_W+1)'(DEPTH);

  // Pointers wrap by width, so the depth must be a power of two
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_chk
    $error("asr_receiver: DEPTH must be a power of two, at least 2");
  end

  // Address match against a register index, used by every decoder
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [9:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0] rsc_r, tsc_r, txb_r, ien_r, flg_r, brg_r;
  logic pready_r, pslverr_r, irq_r;
  logic [31:0] prdata_r;
  logic rx_meta_r, rx_sync_r, rx_prev_r;
  logic [7:0] brg_cnt_r;
  logic [1:0] pre_r;
  asr_state_e state_r;
  logic [3:0] os_cnt_r, bit_cnt_r;
  logic [1:0] smp_r;
  logic [8:0] rsr_r;
  logic overrun_error_r;
  logic [ENTRY_W-1:0] mem_r [DEPTH];
  logic [PTR_W-1:0] wp_r, rp_r;
  logic [PTR_W:0] cnt_r;
  logic rx_en, brg_tick, os_tick, maj, done, filtered, push, ovr_set;
  logic pop, acc, req, mapped, flag;
  logic [3:0] last_bit;
  logic [ENTRY_W-1:0] head;
  logic [7:0] rd_byte;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, answer registered
  assign req = psel_i & penable_i & ~pready_r;
  assign acc = psel_i & penable_i & pready_r;
  assign mapped = hit(paddr_i, IDX_FLAGS) | hit(paddr_i, IDX_RSC) |
                  hit(paddr_i, IDX_TXB) | hit(paddr_i, IDX_RXB) |
                  hit(paddr_i, IDX_IEN) | hit(paddr_i, IDX_TSC) |
                  hit(paddr_i, IDX_BRG);

  // Read mux; framing and ninth status bits come from the buffer head
  always_comb begin
    rd_byte = 8'h00;
    if (hit(paddr_i, IDX_FLAGS)) begin
      rd_byte = flg_r;
      rd_byte[FLG_RCV] = flag; // RQ4
    end
    if (hit(paddr_i, IDX_RSC)) begin
      rd_byte = {rsc_r[7:3], head[ENT_FRAMING_ERROR], overrun_error_r, head[ENT_NINTH]}; // RQ11
    end
    if (hit(paddr_i, IDX_TXB)) begin
      rd_byte = txb_r;
    end
    if (hit(paddr_i, IDX_RXB)) begin
      rd_byte = head[7:0];
    end
    if (hit(paddr_i, IDX_IEN)) begin
      rd_byte = ien_r;
    end
    if (hit(paddr_i, IDX_TSC)) begin
      rd_byte = tsc_r | TSC_RO_SET; // No shifter here, so always empty
    end
    if (hit(paddr_i, IDX_BRG)) begin
      rd_byte = brg_r;
    end
  end

  // Handshake: pready rises one cycle into the access phase
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= req;
      if (req) begin
        pslverr_r <= ~mapped;
        prdata_r <= pwrite_i ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      end else begin
        pslverr_r <= 1'b0;
      end
    end
  end

  // Software registers; writes land at the completing edge
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      rsc_r <= RST_RSC;
      tsc_r <= RST_TSC & TSC_WMASK;
      txb_r <= RST_TXB;
      ien_r <= RST_IEN;
      flg_r <= RST_FLAGS;
      brg_r <= RST_BRG;
    end else if (acc && pwrite_i) begin
      if (hit(paddr_i, IDX_RSC)) begin
        rsc_r <= pwdata_i[7:0] & RSC_WMASK;
      end
      if (hit(paddr_i, IDX_TSC)) begin
        tsc_r <= pwdata_i[7:0] & TSC_WMASK;
      end
      if (hit(paddr_i, IDX_TXB)) begin
        txb_r <= pwdata_i[7:0];
      end
      if (hit(paddr_i, IDX_IEN)) begin
        ien_r <= pwdata_i[7:0];
      end
      if (hit(paddr_i, IDX_FLAGS)) begin
        flg_r <= pwdata_i[7:0] & FLG_WMASK; // RQ4
      end
      if (hit(paddr_i, IDX_BRG)) begin
        brg_r <= pwdata_i[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive enable: async mode, port on, continuous receive on
  assign rx_en = rsc_r[RSC_SERIAL_PORT_ENABLE] & rsc_r[RSC_CONTINUOUS_RECEIVE_ENABLE] & ~tsc_r[TSC_SYNC]; // RQ2 RQ14

  // Pin synchroniser; second stage is sampled, third stage kept for edge detect
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
      rx_prev_r <= 1'b1;
    end else begin
      rx_meta_r <= receive_pin_i;
      rx_sync_r <= rx_meta_r;
      rx_prev_r <= rx_sync_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Baud generator, held in reset while reception is off
  assign brg_tick = rx_en & (brg_cnt_r == brg_r);
  // Low range ticks at x64, so divide by four to reach x16
  assign os_tick = brg_tick &
                   (tsc_r[TSC_HIGH_BAUD_RATE_SELECT] | (pre_r == LOW_PRE_LAST)); // RQ17 RQ20

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || !rx_en) begin
      brg_cnt_r <= 8'h00;
      pre_r <= 2'h0;
    end else if (brg_tick) begin
      brg_cnt_r <= 8'h00; // RQ20
      pre_r <= pre_r + 2'h1;
    end else begin
      brg_cnt_r <= brg_cnt_r + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit recovery: majority of sixteenths 7, 8 and 9
  assign maj = (smp_r[1] & smp_r[0]) | (smp_r[1] & rx_sync_r) |
               (smp_r[0] & rx_sync_r); // RQ22
  assign last_bit = rsc_r[RSC_RX9] ? LAST_BIT9 : LAST_BIT8; // RQ15 RQ18
  assign done = (state_r == ST_STOP) & os_tick & (os_cnt_r == SMP_C);

  // Frame sequencer; dropping the enable aborts any frame in flight
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || !rx_en) begin
      state_r <= ST_IDLE; // RQ2 RQ8
      os_cnt_r <= 4'h0;
      bit_cnt_r <= 4'h0;
      smp_r <= 2'h0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (rx_prev_r && !rx_sync_r) begin
            state_r <= ST_START; // RQ22
            os_cnt_r <= 4'h0;
          end
        end
        ST_START, ST_DATA, ST_STOP: begin
          if (os_tick) begin
            os_cnt_r <= os_cnt_r + 4'h1; // RQ1
            if (os_cnt_r == SMP_A || os_cnt_r == SMP_B) begin
              smp_r <= {smp_r[0], rx_sync_r};
            end
            // A start that reads high at mid-bit was a glitch
            if (os_cnt_r == SMP_C && state_r == ST_START && maj) begin
              state_r <= ST_IDLE;
            end
            if (os_cnt_r == SMP_C && state_r == ST_STOP) begin
              state_r <= ST_IDLE; // RQ18
            end
            if (os_cnt_r == BIT_END && state_r == ST_START) begin
              state_r <= ST_DATA;
              bit_cnt_r <= 4'h0;
            end
            if (os_cnt_r == BIT_END && state_r == ST_DATA) begin
              if (bit_cnt_r == last_bit) begin
                state_r <= ST_STOP;
              end else begin
                bit_cnt_r <= bit_cnt_r + 4'h1;
              end
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Shift register filled least significant bit first
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || state_r == ST_IDLE) begin
      rsr_r <= 9'h000;
    end else if (state_r == ST_DATA && os_tick && os_cnt_r == SMP_C) begin
      rsr_r[bit_cnt_r] <= maj; // RQ19
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word completion: filter, overrun, load
  assign filtered = rsc_r[RSC_ADDRESS_DETECT_ENABLE] & rsc_r[RSC_RX9] & ~rsr_r[8]; // RQ16 RQ21
  assign push = done & ~filtered & ~overrun_error_r & (cnt_r != CNT_FULL); // RQ3 RQ9
  assign ovr_set = done & ~filtered & ~overrun_error_r & (cnt_r == CNT_FULL); // RQ7

  // Overrun is sticky until receive enable drops; set wins
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      overrun_error_r <= 1'b0;
    end else if (ovr_set) begin
      overrun_error_r <= 1'b1; // RQ7
    end else if (!rsc_r[RSC_CONTINUOUS_RECEIVE_ENABLE]) begin
      overrun_error_r <= 1'b0; // RQ8
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive buffer: each entry is {framing, ninth, data}
  assign pop = acc & ~pwrite_i & hit(paddr_i, IDX_RXB) & (cnt_r != '0);
  assign head = (cnt_r != '0) ? mem_r[rp_r] : '0;
  assign flag = (cnt_r != '0); // RQ4

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem_r[wp_r] <= {~maj, rsr_r[8], rsr_r[7:0]}; // RQ10 RQ11
    end
  end

  // Push and pop in one cycle leave the count alone
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1; // RQ6
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1; // RQ13
      end
      case ({push, pop})
        2'b10: cnt_r <= cnt_r + 1'b1;
        2'b01: cnt_r <= cnt_r - 1'b1;
        default: cnt_r <= cnt_r;
      endcase
    end
  end

  // Request follows the flag only while enabled
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= flag & ien_r[IEN_RCV]; // RQ5
    end
  end

  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign receive_irq_o = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_push_flag: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    push |=> flag) // RQ3
    else $error("flag not set after load");
  chk_irq_gate: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    receive_irq_o |-> $past(ien_r[IEN_RCV]) && $past(flag)) // RQ5
    else $error("interrupt without enable");
  chk_ovr_sticky: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    overrun_error_r && rsc_r[RSC_CONTINUOUS_RECEIVE_ENABLE] |=> overrun_error_r) // RQ8
    else $error("overrun cleared on its own");
  // Buffer must never grow while overrun stands, whatever drives the load
  chk_ovr_block: assert property (@(posedge mclk_i) // RQ9
    disable iff (!reset_n_i)
    overrun_error_r |=> cnt_r <= $past(cnt_r))
    else $error("load during overrun");
  chk_full_ovr: assert property (@(posedge mclk_i) // RQ7
    disable iff (!reset_n_i)
    done && !filtered && cnt_r == CNT_FULL |=> overrun_error_r && cnt_r <= CNT_FULL)
    else $error("full buffer did not overrun");
  chk_pop_order: assert property (@(posedge mclk_i) // RQ13
    disable iff (!reset_n_i)
    pop && !push |=> cnt_r == $past(cnt_r) - 1'b1 && rp_r != $past(rp_r))
    else $error("read did not remove one entry");
  chk_off_idle: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    !rx_en |=> state_r == ST_IDLE && !done) // RQ2
    else $error("receiving while disabled");
  chk_os_div: assert property (@(posedge mclk_i) // RQ20
    disable iff (!reset_n_i)
    os_tick && !tsc_r[TSC_HIGH_BAUD_RATE_SELECT] |-> pre_r == LOW_PRE_LAST && brg_tick)
    else $error("low range tick not divided");
  chk_addr_load: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    push && rsc_r[RSC_ADDRESS_DETECT_ENABLE] && rsc_r[RSC_RX9] |=>
    mem_r[$past(wp_r)][ENT_NINTH]) // RQ21
    else $error("data word loaded under address detect");
  chk_apb_ready: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o)
    else $error("ready not one cycle after wait");
  chk_empty_flag: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    pop && cnt_r == 1 && !push |=> !flag ##1 !receive_irq_o) // RQ4
    else $error("flag stuck after buffer emptied");

endmodule : asr_receiver

// [tb/asr_tx_model.sv]
// Purpose: Remote asynchronous transmitter driving the receive pin.
// Assumes: Bit time is a whole number of mclk cycles, set by the bench.
// Notes: Line idles high; an open frame always ends with idle time.
`timescale 1ns/1ns
module asr_tx_model (
  input wire logic mclk_i,
  output logic line_o
);
  // Bit time in mclk cycles; bench changes it with the baud setting
  int bit_clks = 16;

  initial line_o = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // One frame: start, 8 or 9 data bits, stop, then idle gap
  task automatic send(input logic [8:0] word, input logic nine,
                      input logic stop_ok);
    int n;
    n = nine ? 9 : 8;
    line_o <= 1'b0;
    repeat (bit_clks) @(posedge mclk_i);
    for (int i = 0; i < n; i++) begin
      line_o <= word[i];
      repeat (bit_clks) @(posedge mclk_i);
    end
    line_o <= stop_ok;
    repeat (bit_clks) @(posedge mclk_i);
    // Idle gap lets a bad stop bit recover before the next start
    line_o <= 1'b1;
    repeat (2 * bit_clks) @(posedge mclk_i);
  endtask : send
endmodule : asr_tx_model

// [tb/asr_receiver_tb.sv]
// Purpose: Self-checking bench for the serial receiver over APB.
// Assumes: Divisor 0, so a bit lasts 16 or 64 mclk cycles.
// Notes: A queue model predicts buffer, flag and error bits.
`timescale 1ns/1ns
module asr_receiver_tb;
  import asr_pkg::*;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic line;
  logic receive_irq_o;
  logic [31:0] rdat;
  logic rerr;
  logic [7:0] lfsr_r = 8'h13;
  logic [9:0] q[$];
  logic [7:0] cfg = 8'h00;
  logic [7:0] ien = 8'h00;
  logic ovr = 1'b0;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;

  asr_receiver uut (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o),
    .receive_pin_i(line), .receive_irq_o(receive_irq_o));
  asr_tx_model tx (.mclk_i(mclk_i), .line_o(line));

  initial forever #10 mclk_i = ~mclk_i;

  ////////////////////////////////////////////////////////////////////////////
  // Report and checks
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // Hang guard; the whole run needs well under this many cycles
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB master: hold request until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [9:0] idx,
                     input logic [7:0] wd);
    int t;
    t = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge mclk_i);
    penable <= 1'b1;
    // Wait as long as it takes; only the hang guard ends a stuck wait
    do begin
      @(posedge mclk_i);
      t++;
    end while (pready_o !== 1'b1);
    chk(t, 2, "wait states");
    rdat = prdata_o;
    rerr = pslverr_o;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk_i);
  endtask : apb

  // Control write also keeps the model's copy; receive enable off clears
  task automatic set_cfg(input logic [7:0] v);
    apb(1'b1, IDX_RSC, v);
    cfg = v;
    if (!v[RSC_CONTINUOUS_RECEIVE_ENABLE]) ovr = 1'b0;
  endtask : set_cfg

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next

  ////////////////////////////////////////////////////////////////////////////
  // Send one frame and predict what the buffer does with it
  task automatic rx(input logic ninth, input logic stop_ok);
    logic nine;
    logic [8:0] w;
    lfsr_r = lfsr_next(lfsr_r);
    w = {ninth, lfsr_r};
    nine = cfg[RSC_RX9];
    tx.send(w, nine, stop_ok);
    if (cfg[RSC_SERIAL_PORT_ENABLE] && cfg[RSC_CONTINUOUS_RECEIVE_ENABLE] && !ovr &&
        !(nine && cfg[RSC_ADDRESS_DETECT_ENABLE] && !ninth)) begin
      if (q.size() >= 2) ovr = 1'b1;
      else q.push_back({~stop_ok, nine & ninth, w[7:0]});
    end
  endtask : rx

  // Status, flag and request line against the model
  task automatic chk_state();
    logic [9:0] h;
    h = (q.size() != 0) ? q[0] : 10'h000;
    apb(1'b0, IDX_RSC, 8'h00);
    chk(rdat, {24'h0, cfg[7:3], h[ENT_FRAMING_ERROR], ovr, h[ENT_NINTH]}, "status");
    apb(1'b0, IDX_FLAGS, 8'h00);
    chk(rdat[FLG_RCV], q.size() != 0, "flag");
    chk(receive_irq_o, (q.size() != 0) && ien[IEN_RCV], "irq");
  endtask : chk_state

  task automatic rd_buf();
    logic [9:0] h;
    h = (q.size() != 0) ? q.pop_front() : 10'h000;
    apb(1'b0, IDX_RXB, 8'h00);
    chk(rdat, {24'h0, h[7:0]}, "buffer");
  endtask : rd_buf

  task automatic set_ien(input logic [7:0] v);
    apb(1'b1, IDX_IEN, v);
    ien = v;
  endtask : set_ien

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [9:0] ridx[6];
    logic [7:0] rval[6];
    ridx = '{IDX_FLAGS, IDX_RSC, IDX_TXB, IDX_IEN, IDX_TSC, IDX_BRG};
    rval = '{RST_FLAGS, RST_RSC, RST_TXB, RST_IEN, RST_TSC, RST_BRG};
    repeat (20) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    @(posedge mclk_i);
    foreach (ridx[i]) begin
      apb(1'b0, ridx[i], 8'h00);
      chk(rdat, {24'h0, rval[i]}, "reset value");
      chk(rerr, 1'b0, "mapped");
    end
    apb(1'b0, 10'h001, 8'h00);
    chk(rerr, 1'b1, "unmapped");
    $display("test reset done");
    apb(1'b1, IDX_BRG, 8'h00);
    apb(1'b1, IDX_TSC, 8'h04);
    set_ien(8'h20);
    set_cfg(8'h80);
    rx(1'b0, 1'b1);
    chk_state();
    set_cfg(8'h90);
    rx(1'b0, 1'b1);
    rx(1'b0, 1'b1);
    chk_state();
    rd_buf();
    chk_state();
    rd_buf();
    chk_state();
    apb(1'b1, IDX_FLAGS, 8'hff);
    apb(1'b0, IDX_FLAGS, 8'h00);
    chk(rdat, {24'h0, FLG_WMASK}, "flag write");
    apb(1'b1, IDX_FLAGS, 8'h00);
    $display("test basic done");
    repeat (3) rx(1'b0, 1'b1);
    chk_state();
    rx(1'b0, 1'b1);
    rd_buf();
    rd_buf();
    chk_state();
    set_cfg(8'h80);
    set_cfg(8'h90);
    rx(1'b0, 1'b1);
    chk_state();
    rd_buf();
    $display("test overrun done");
    rx(1'b0, 1'b0);
    chk_state();
    rd_buf();
    set_ien(8'h00);
    rx(1'b0, 1'b1);
    chk_state();
    rd_buf();
    set_ien(8'h20);
    $display("test framing done");
    set_cfg(8'hd0);
    rx(1'b1, 1'b1);
    rx(1'b0, 1'b1);
    chk_state();
    rd_buf();
    chk_state();
    rd_buf();
    set_cfg(8'hd8);
    rx(1'b0, 1'b1);
    rx(1'b1, 1'b1);
    chk_state();
    rd_buf();
    set_cfg(8'hd0);
    rx(1'b0, 1'b1);
    rd_buf();
    $display("test nine bit done");
    apb(1'b1, IDX_TSC, 8'h00);
    tx.bit_clks = 64;
    set_cfg(8'h90);
    rx(1'b0, 1'b1);
    chk_state();
    rd_buf();
    $display("test slow baud done");
    stop_test();
  end
endmodule : asr_receiver_tb
